/* File: rtl/hc_alarm_pkg.sv */
// Package: register map, encodings and timing constants of the heat-cool alarm logic
package hc_alarm_pkg;

  // Bus register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_BAND      = 8'h04;
  localparam logic [7:0] OFS_ALM1      = 8'h08;
  localparam logic [7:0] OFS_ALM2      = 8'h0c;
  localparam logic [7:0] OFS_LVL1      = 8'h10;
  localparam logic [7:0] OFS_LVL2      = 8'h14;
  localparam logic [7:0] OFS_SETPT     = 8'h18;
  localparam logic [7:0] OFS_PV1       = 8'h1c;
  localparam logic [7:0] OFS_PV2       = 8'h20;
  localparam logic [7:0] OFS_DWELL     = 8'h24;
  localparam logic [7:0] OFS_DEMAND    = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h2c;
  localparam logic [7:0] OFS_ALMRST    = 8'h30;

  // Control register fields
  localparam int CTRL_DIRECT    = 0;
  localparam int CTRL_SEC_COOL  = 1;
  localparam int CTRL_PB2_SEL   = 2;
  localparam int CTRL_HEAT_ONOFF = 3;
  localparam int CTRL_COOL_ONOFF = 4;
  localparam int CTRL_PRI_LIN   = 5;
  localparam int CTRL_SEC_LIN   = 6;
  localparam int CTRL_W         = 7;

  // Field positions inside the band register
  localparam int BAND_CPB_LSB = 0;
  localparam int BAND_DB_LSB  = 8;
  localparam int BAND_PB1_LSB = 16;
  localparam int BAND_PB2_LSB = 24;

  // Field positions inside alarm configuration registers
  localparam int ALM_FN_LSB  = 0;
  localparam int ALM_MD_LSB  = 4;
  localparam int ALM_HY_LSB  = 8;
  localparam int ALM_DV_LSB  = 16;

  // Limits of settings
  localparam logic [7:0]  CPB_MIN  = 8'h01;
  localparam logic [7:0]  CPB_MAX  = 8'hff;
  localparam logic [7:0]  CPB_RST  = 8'h64;
  localparam logic signed [9:0] DB_LIM = 10'sd360;
  localparam logic [15:0] DWELL_MAX = 16'hffff;

  // Alarm functions
  typedef enum logic [3:0] {
    first_value_high_alarm  = 4'h0,
    first_value_low_alarm   = 4'h1,
    second_value_high_alarm = 4'h2,
    second_value_low_alarm  = 4'h3,
    either_value_high_alarm = 4'h4,
    either_value_low_alarm  = 4'h5,
    difference_high_alarm   = 4'h6,
    difference_low_alarm    = 4'h7,
    deviation_high_alarm    = 4'h8,
    deviation_low_alarm     = 4'h9,
    dwell_timer_function    = 4'ha,
    alarm_off               = 4'hf
  } alarm_fn_t;

  // Alarm modes
  typedef enum logic [1:0] {
    normal_alarm_mode     = 2'b00,
    latching_alarm_mode   = 2'b01,
    holding_alarm_mode    = 2'b10,
    latch_hold_alarm_mode = 2'b11
  } alarm_mode_t;

  // Configuration error code for two dwell timers
  localparam logic [7:0] ERR_TWO_TIMERS = 8'h07;

  // Dwell tick: one tenth of a minute
  localparam int  TICK_MS   = 6000;
  localparam int  CLK_MHZ   = 125;
  localparam longint TICK_CYCLES = longint'(TICK_MS) * 1000 * CLK_MHZ;

endpackage : hc_alarm_pkg

/* File: rtl/alarm_channel.sv */
// One alarm channel: process, deviation or dwell timer with latch/hold modes
`timescale 1ns/1ns
module alarm_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Configuration
  input  wire logic [3:0]            fn,
  input  wire logic [1:0]            mode,
  input  wire logic signed [W-1:0]   level,
  input  wire logic signed [W-1:0]   deviation,
  input  wire logic [7:0]            hysteresis,
  input  wire logic [15:0]           dwell_time,
  // Process state
  input  wire logic signed [W-1:0]   pv1,
  input  wire logic signed [W-1:0]   pv2,
  input  wire logic signed [W-1:0]   sp1,
  input  wire logic                  sp_reached,
  input  wire logic                  tick,
  input  wire logic                  alarm_reset,
  // Output
  output logic                       alarm_out,
  output logic [15:0]                dwell_count
);

  localparam logic [1:0] LATCH_BIT = 2'b01;
  localparam logic [1:0] HOLD_BIT  = 2'b10;

  logic signed [W:0] hi_thr, lo_thr, ref_lvl, diff, half;
  logic signed [W:0] p1, p2;
  logic              cond_on, cond_off;
  logic              cond_reg, armed_reg, latch_reg, timed_out_reg, run_reg;

  // Thresholds: reference plus or minus half hysteresis
  always_comb begin
    p1   = (W+1)'(pv1);
    p2   = (W+1)'(pv2);
    diff = p1 - p2;
    half = (W+1)'({1'b0, hysteresis} >> 1);
    if (fn == hc_alarm_pkg::deviation_high_alarm ||
        fn == hc_alarm_pkg::deviation_low_alarm)
      ref_lvl = (W+1)'(sp1) + (W+1)'(deviation);
    else
      ref_lvl = (W+1)'(level);
    hi_thr = ref_lvl + half;
    lo_thr = ref_lvl - half;
  end

  // Condition on and off tests per function
  always_comb begin
    cond_on  = 1'b0;
    cond_off = 1'b0;
    unique case (fn)
      hc_alarm_pkg::first_value_high_alarm,
      hc_alarm_pkg::deviation_high_alarm: begin
        cond_on  = p1 > hi_thr;
        cond_off = p1 < lo_thr;
      end
      hc_alarm_pkg::first_value_low_alarm,
      hc_alarm_pkg::deviation_low_alarm: begin
        cond_on  = p1 < lo_thr;
        cond_off = p1 > hi_thr;
      end
      hc_alarm_pkg::second_value_high_alarm: begin
        cond_on  = p2 > hi_thr;
        cond_off = p2 < lo_thr;
      end
      hc_alarm_pkg::second_value_low_alarm: begin
        cond_on  = p2 < lo_thr;
        cond_off = p2 > hi_thr;
      end
      hc_alarm_pkg::either_value_high_alarm: begin
        cond_on  = (p1 > hi_thr) || (p2 > hi_thr);
        cond_off = (p1 < lo_thr) && (p2 < lo_thr);
      end
      hc_alarm_pkg::either_value_low_alarm: begin
        cond_on  = (p1 < lo_thr) || (p2 < lo_thr);
        cond_off = (p1 > hi_thr) && (p2 > hi_thr);
      end
      hc_alarm_pkg::difference_high_alarm: begin
        cond_on  = diff > hi_thr;
        cond_off = diff < lo_thr;
      end
      hc_alarm_pkg::difference_low_alarm: begin
        cond_on  = diff < lo_thr;
        cond_off = diff > hi_thr;
      end
      default: begin
        cond_on  = 1'b0;
        cond_off = 1'b1;
      end
    endcase
  end

  // Hysteretic alarm condition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cond_reg <= 1'b0;
    else if (cond_on) cond_reg <= 1'b1;
    else if (cond_off) cond_reg <= 1'b0;
  end

  // Holding: armed once the set point is first reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) armed_reg <= 1'b0;
    else if (sp_reached) armed_reg <= 1'b1;
  end

  // Latch: set wins over the reset event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) latch_reg <= 1'b0;
    else if (cond_reg && ((mode & LATCH_BIT) != 2'b00)) latch_reg <= 1'b1;
    else if (alarm_reset) latch_reg <= 1'b0;
  end

  // Dwell timer: starts at zero on set point, counts tenths of minutes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg       <= 1'b0;
      dwell_count   <= 16'h0000;
      timed_out_reg <= 1'b0;
    end else if (fn != hc_alarm_pkg::dwell_timer_function) begin
      run_reg       <= 1'b0;
      dwell_count   <= 16'h0000;
      timed_out_reg <= 1'b0;
    end else if (!run_reg && !timed_out_reg && sp_reached) begin
      run_reg     <= 1'b1;
      dwell_count <= 16'h0000;
    end else if (run_reg) begin
      if (dwell_count >= dwell_time) begin
        run_reg       <= 1'b0;
        timed_out_reg <= 1'b1;
      end else if (tick) begin
        dwell_count <= dwell_count + 16'h0001;
      end
    end
  end

  // Output: dwell timer and alarm off ignore mode others apply mode
  always_comb begin
    if (fn == hc_alarm_pkg::dwell_timer_function)
      alarm_out = timed_out_reg;
    else if (fn == hc_alarm_pkg::alarm_off)
      alarm_out = 1'b0;
    else if (((mode & HOLD_BIT) != 2'b00) && !armed_reg)
      alarm_out = 1'b0;
    else if ((mode & LATCH_BIT) != 2'b00)
      alarm_out = cond_reg | latch_reg;
    else
      alarm_out = cond_reg;
  end

endmodule // alarm_channel

/* File: rtl/heat_cool_split.sv */
// Splits a signed control demand into heat and cool outputs
`timescale 1ns/1ns
module heat_cool_split #(
  parameter int W = 16
) (
  // Settings
  input  wire logic signed [W-1:0] error,
  input  wire logic [7:0]          band,
  input  wire logic [7:0]          cooling_band_percent,
  input  wire logic signed [9:0]   dead_band,
  input  wire logic                heat_onoff,
  input  wire logic                cool_onoff,
  // Demands, 0 to 1000 per mille
  output logic [9:0]               heat_demand,
  output logic [9:0]               cool_demand
);

  localparam int FULL = 1000;

  logic signed [31:0] e, db_off, heat_e, cool_e, pb_h, pb_c, h, c;

  // Error is set point minus process value, scaled in tenths
  always_comb begin
    e      = 32'(error);
    pb_h   = (band == 8'h00) ? 32'sd1 : 32'(band) * 32'sd10;
    pb_c   = (pb_h * 32'($unsigned(cooling_band_percent))) / 32'sd100;
    if (pb_c == 32'sd0) pb_c = 32'sd1;
    // Dead band in tenths of percent of the active band
    db_off = (pb_h * 32'(dead_band)) / 32'sd1000;
    heat_e = e - db_off / 32'sd2;
    cool_e = -e - db_off / 32'sd2;
    h = (heat_e * 32'sd1000) / pb_h;
    c = (cool_e * 32'sd1000) / pb_c;
    if (heat_onoff) h = (heat_e > 32'sd0) ? FULL : 0;
    if (cool_onoff) c = (cool_e > 32'sd0) ? FULL : 0;
    // Negative dead band lets both be active positive keeps both off
    heat_demand = (h <= 0) ? 10'h000 : (h >= FULL) ? 10'(FULL) : 10'(h);
    cool_demand = (c <= 0) ? 10'h000 : (c >= FULL) ? 10'(FULL) : 10'(c);
  end

endmodule // heat_cool_split

/* File: rtl/heat_cool_ctrl.sv */
// Heat-cool output steering and two alarm channels behind an AHB-Lite slave
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module heat_cool_ctrl #(
  parameter int     W           = 16,
  parameter longint TICK_CYCLES = hc_alarm_pkg::TICK_CYCLES
) (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Event input with alarm reset function selected
  input  wire logic        event_input_function,
  // Actuator outputs
  output logic [9:0]       primary_demand,
  output logic [9:0]       secondary_demand,
  output logic             primary_linear,
  output logic             secondary_linear,
  output logic             alarm_one_out,
  output logic             alarm_two_out,
  output logic [7:0]       error_code
);

  logic [hc_alarm_pkg::CTRL_W-1:0] ctrl_reg;
  logic [7:0]          cpb_reg, pb1_reg, pb2_reg;
  logic signed [9:0]   db_reg;
  logic [31:0]         alm1_reg, alm2_reg;
  logic signed [W-1:0] lvl1_reg, lvl2_reg, sp_reg, pv1_reg, pv2_reg;
  logic [15:0]         dwell_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic                sp_reached_reg, ev_d_reg, tick_reg;
  logic [39:0]         tick_cnt_reg;
  logic [15:0]         cnt1, cnt2;
  logic [9:0]          heat_d, cool_d;
  logic [7:0]          cpb_w;
  logic signed [9:0]   db_w;
  logic                alarm_reset, dual_timer;
  logic [7:0]          act_band;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture of writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Clamp written cooling band and dead band settings to their legal ranges
  always_comb begin
    cpb_w = hwdata[hc_alarm_pkg::BAND_CPB_LSB +: 8];
    if (cpb_w < hc_alarm_pkg::CPB_MIN) cpb_w = hc_alarm_pkg::CPB_MIN;
    db_w = hwdata[hc_alarm_pkg::BAND_DB_LSB +: 10];
    if (db_w > hc_alarm_pkg::DB_LIM) db_w = hc_alarm_pkg::DB_LIM;
    if (db_w < -hc_alarm_pkg::DB_LIM) db_w = -hc_alarm_pkg::DB_LIM;
  end

  // Register writes; band setting only changes on software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= '0;
      cpb_reg   <= hc_alarm_pkg::CPB_RST;
      db_reg    <= '0;
      pb1_reg   <= '0;
      pb2_reg   <= '0;
      alm1_reg  <= 32'h0000_000f;
      alm2_reg  <= 32'h0000_000f;
      lvl1_reg  <= '0;
      lvl2_reg  <= '0;
      sp_reg    <= '0;
      pv1_reg   <= '0;
      pv2_reg   <= '0;
      dwell_reg <= '0;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        hc_alarm_pkg::OFS_CTRL:  ctrl_reg <= hwdata[hc_alarm_pkg::CTRL_W-1:0];
        hc_alarm_pkg::OFS_BAND: begin
          cpb_reg <= cpb_w;
          db_reg  <= db_w;
          pb1_reg <= hwdata[hc_alarm_pkg::BAND_PB1_LSB +: 8];
          pb2_reg <= hwdata[hc_alarm_pkg::BAND_PB2_LSB +: 8];
        end
        hc_alarm_pkg::OFS_ALM1:  alm1_reg  <= hwdata;
        hc_alarm_pkg::OFS_ALM2:  alm2_reg  <= hwdata;
        hc_alarm_pkg::OFS_LVL1:  lvl1_reg  <= hwdata[W-1:0];
        hc_alarm_pkg::OFS_LVL2:  lvl2_reg  <= hwdata[W-1:0];
        hc_alarm_pkg::OFS_SETPT: sp_reg    <= hwdata[W-1:0];
        hc_alarm_pkg::OFS_PV1:   pv1_reg   <= hwdata[W-1:0];
        hc_alarm_pkg::OFS_PV2:   pv2_reg   <= hwdata[W-1:0];
        hc_alarm_pkg::OFS_DWELL: dwell_reg <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Alarm reset from event input edge or software strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_d_reg <= 1'b0;
    else ev_d_reg <= event_input_function;
  end
  assign alarm_reset = (event_input_function && !ev_d_reg) ||
                       (wr_pend_reg && wr_addr_reg == hc_alarm_pkg::OFS_ALMRST
                        && hwdata[0]);

  // Process has reached the set point (from below, or from above when direct is set)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sp_reached_reg <= 1'b0;
    else sp_reached_reg <= ctrl_reg[hc_alarm_pkg::CTRL_DIRECT] ?
                           (pv1_reg <= sp_reg) : (pv1_reg >= sp_reg);
  end

  // Tenth-of-a-minute tick generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= 40'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 40'h1;
      tick_reg     <= 1'b0;
    end
  end

  // Two alarm channels
  generate
    for (genvar i = 0; i < 2; i++) begin : g_alm
      logic [31:0] cfg;
      logic        out;
      logic [15:0] cnt;
      assign cfg = (i == 0) ? alm1_reg : alm2_reg;
      alarm_channel #(.W(W)) u_ch (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .fn          (cfg[hc_alarm_pkg::ALM_FN_LSB +: 4]),
        .mode        (cfg[hc_alarm_pkg::ALM_MD_LSB +: 2]),
        .level       ((i == 0) ? lvl1_reg : lvl2_reg),
        .deviation   (W'($signed(cfg[hc_alarm_pkg::ALM_DV_LSB +: 16]))),
        .hysteresis  (cfg[hc_alarm_pkg::ALM_HY_LSB +: 8]),
        .dwell_time  (dwell_reg),
        .pv1         (pv1_reg),
        .pv2         (pv2_reg),
        .sp1         (sp_reg),
        .sp_reached  (sp_reached_reg),
        .tick        (tick_reg),
        .alarm_reset (alarm_reset),
        .alarm_out   (out),
        .dwell_count (cnt)
      );
    end
  endgenerate
  assign cnt1 = g_alm[0].cnt;
  assign cnt2 = g_alm[1].cnt;
  // Alarm relays: driven straight from the two alarm channel outputs
  assign alarm_one_out = g_alm[0].out;
  assign alarm_two_out = g_alm[1].out;

  // Two dwell timers is a configuration error
  assign dual_timer =
    (alm1_reg[3:0] == hc_alarm_pkg::dwell_timer_function) &&
    (alm2_reg[3:0] == hc_alarm_pkg::dwell_timer_function);
  assign error_code = dual_timer ? hc_alarm_pkg::ERR_TWO_TIMERS : 8'h00;

  // Active heating band: first or second
  assign act_band = ctrl_reg[hc_alarm_pkg::CTRL_PB2_SEL] ? pb2_reg : pb1_reg;

  heat_cool_split #(.W(W)) u_split (
    .error       (sp_reg - pv1_reg),
    .band        (act_band),
    .cooling_band_percent         (cpb_reg),
    .dead_band   (db_reg),
    .heat_onoff  (ctrl_reg[hc_alarm_pkg::CTRL_HEAT_ONOFF] ||
                  act_band == 8'h00),
    .cool_onoff  (ctrl_reg[hc_alarm_pkg::CTRL_COOL_ONOFF] ||
                  act_band == 8'h00),
    .heat_demand (heat_d),
    .cool_demand (cool_d)
  );

  // Output steering across the four combinations
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_demand   <= '0;
      secondary_demand <= '0;
    end else begin
      primary_demand   <= ctrl_reg[hc_alarm_pkg::CTRL_DIRECT] ?
                          cool_d : heat_d;
      secondary_demand <= ctrl_reg[hc_alarm_pkg::CTRL_SEC_COOL] ?
                          cool_d : 10'h000;
    end
  end

  // Linear outputs take no proportioning cycle
  assign primary_linear   = ctrl_reg[hc_alarm_pkg::CTRL_PRI_LIN];
  assign secondary_linear = ctrl_reg[hc_alarm_pkg::CTRL_SEC_LIN];

  // Read data in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= '0;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        hc_alarm_pkg::OFS_CTRL:   hrdata <= 32'(ctrl_reg);
        hc_alarm_pkg::OFS_BAND:   hrdata <= {pb2_reg, pb1_reg,
                                             db_reg[7:0], cpb_reg};
        hc_alarm_pkg::OFS_ALM1:   hrdata <= alm1_reg;
        hc_alarm_pkg::OFS_ALM2:   hrdata <= alm2_reg;
        hc_alarm_pkg::OFS_LVL1:   hrdata <= 32'($signed(lvl1_reg));
        hc_alarm_pkg::OFS_LVL2:   hrdata <= 32'($signed(lvl2_reg));
        hc_alarm_pkg::OFS_SETPT:  hrdata <= 32'($signed(sp_reg));
        hc_alarm_pkg::OFS_PV1:    hrdata <= 32'($signed(pv1_reg));
        hc_alarm_pkg::OFS_PV2:    hrdata <= 32'($signed(pv2_reg));
        hc_alarm_pkg::OFS_DWELL:  hrdata <= {cnt2, cnt1};
        hc_alarm_pkg::OFS_DEMAND: hrdata <= {6'h00, secondary_demand,
                                             6'h00, primary_demand};
        hc_alarm_pkg::OFS_STATUS: hrdata <= {21'h0, sp_reached_reg,
                                             alarm_two_out, alarm_one_out,
                                             error_code};
        default:                  hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // heat_cool_ctrl

/* File: verif/hc_checker.sv */
// Checker: bus, linear flags, error code and demand relations at the ports
`timescale 1ns/1ns
module hc_checker (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Outputs watched
  input wire logic [9:0]  primary_demand,
  input wire logic [9:0]  secondary_demand,
  input wire logic        primary_linear,
  input wire logic        secondary_linear,
  input wire logic [7:0]  error_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        ph;
  logic [7:0]  pa;
  logic [31:0] ctrl_q;
  logic [31:0] a1_q;
  logic [31:0] a2_q;
  // Address phase capture of writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 1'b0;
      pa <= 8'h00;
    end else if (hready) begin
      ph <= hsel & htrans[1] & hwrite;
      pa <= haddr[7:0];
    end
  end
  // Shadow copies of written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0;
      a1_q   <= 32'hf;
      a2_q   <= 32'hf;
    end else if (hready && ph) begin
      if (pa == hc_alarm_pkg::OFS_CTRL) ctrl_q <= hwdata;
      if (pa == hc_alarm_pkg::OFS_ALM1) a1_q <= hwdata;
      if (pa == hc_alarm_pkg::OFS_ALM2) a2_q <= hwdata;
    end
  end
  sequence ctrl_wr;
    ph && hready && pa == hc_alarm_pkg::OFS_CTRL;
  endsequence
  sequence two_tmr;
    (a1_q[3:0] == 4'ha && a2_q[3:0] == 4'ha) [*2];
  endsequence
  sequence not_two;
    !(a1_q[3:0] == 4'ha && a2_q[3:0] == 4'ha) [*2];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_pri_linear: assert property (ctrl_wr |=> primary_linear == ctrl_q[5])
    else $error("primary linear flag wrong");
  a_sec_linear: assert property (ctrl_wr |=> secondary_linear == ctrl_q[6])
    else $error("secondary linear flag wrong");
  a_two_timers: assert property (two_tmr |-> error_code == 8'h07)
    else $error("missing two timer error");
  a_one_timer: assert property (not_two |-> error_code == 8'h00)
    else $error("spurious error code");
  a_sec_idle: assert property ((!ctrl_q[1]) [*3] |-> secondary_demand == 0)
    else $error("secondary demand while not cooling");
  a_demand_max: assert property (primary_demand <= 10'd1000)
    else $error("primary demand above full scale");
endmodule // hc_checker
bind heat_cool_ctrl hc_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .primary_demand(primary_demand), .secondary_demand(secondary_demand),
  .primary_linear(primary_linear), .secondary_linear(secondary_linear),
  .error_code(error_code));

/* File: verif/operator_model.sv */
// Operator side: raises the event input on request
`timescale 1ns/1ns
module operator_model (
  // Clock and request
  input wire logic hclk,
  input wire logic reset_req,
  // Event line to the device
  output logic     event_input_function
);
  initial event_input_function = 1'b0;
  // Event follows the request one cycle later, off the bus timing
  always @(posedge hclk) begin
    event_input_function <= reset_req;
  end
endmodule // operator_model

/* File: verif/testbench.sv */
// Testbench: register tests over AHB-Lite for the heat-cool alarm logic
`timescale 1ns/1ns
module testbench;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ev_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, pl, sl, a1, a2, evi;
  logic [9:0]  pd, sd;
  logic [7:0]  ec;
  logic [31:0] cfg [3] = '{32'h00000a00, 32'h00000a06, 32'h00320a08};
  logic [15:0] pv [5] = '{16'd210, 16'd204, 16'd194, 16'd204, 16'd206};
  logic        ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int          fails = 0, tests_run = 0;
  assign hready = hreadyout;
  // Clock
  initial begin
    forever #4 hclk = ~hclk;
  end
  heat_cool_ctrl #(.TICK_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .event_input_function(evi), .primary_demand(pd),
    .secondary_demand(sd), .primary_linear(pl), .secondary_linear(sl),
    .alarm_one_out(a1), .alarm_two_out(a2), .error_code(ec));
  operator_model u_op (.hclk(hclk), .reset_req(ev_req),
    .event_input_function(evi));
  // One single transfer, read data left in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, hc_alarm_pkg::OFS_BAND, 0); chk(q & 32'hff, 32'h64);
    bus(0, hc_alarm_pkg::OFS_ALM1, 0); chk(q & 32'hf, 32'hf);
    bus(1, hc_alarm_pkg::OFS_BAND, 32'h0001f400);
    bus(0, hc_alarm_pkg::OFS_BAND, 0); chk(q & 32'hffff, 32'h6801);
    bus(1, hc_alarm_pkg::OFS_BAND, 32'h00020cff);
    bus(0, hc_alarm_pkg::OFS_BAND, 0); chk(q & 32'hffff, 32'h98ff);
    $display("test settings done");
    bus(1, hc_alarm_pkg::OFS_ALM1, 32'ha);
    bus(1, hc_alarm_pkg::OFS_ALM2, 32'ha);
    repeat (2) @(posedge hclk); chk({24'h0, ec}, 32'h07);
    bus(1, hc_alarm_pkg::OFS_ALM2, 32'hf);
    repeat (2) @(posedge hclk); chk({24'h0, ec}, 32'h00);
    bus(1, hc_alarm_pkg::OFS_CTRL, 32'h60);
    @(posedge hclk); chk({30'h0, pl, sl}, 32'h3);
    $display("test timers and outputs done");
    // Process, difference and deviation walks round a 200 +/- 5 band
    for (int k = 0; k < 3; k++) begin
      bus(1, hc_alarm_pkg::OFS_ALM1, cfg[k]);
      bus(1, hc_alarm_pkg::OFS_LVL1, 32'd200);
      bus(1, hc_alarm_pkg::OFS_SETPT, 32'd150);
      bus(1, hc_alarm_pkg::OFS_PV1, (k == 1) ? 32'd310 : 32'd0);
      for (int i = 0; i < 5; i++) begin
        if (k == 1) bus(1, hc_alarm_pkg::OFS_PV2, 32'(16'd310 - pv[i]));
        else bus(1, hc_alarm_pkg::OFS_PV1, 32'(pv[i]));
        repeat (2) @(posedge hclk);
        chk({31'h0, a1}, {31'h0, ex[i]});
      end
    end
    $display("test alarm functions done");
    bus(1, hc_alarm_pkg::OFS_ALM1, 32'h00000a10);
    bus(1, hc_alarm_pkg::OFS_PV1, 32'd210);
    bus(1, hc_alarm_pkg::OFS_PV1, 32'd100);
    repeat (2) @(posedge hclk); chk({31'h0, a1}, 32'h1);
    bus(0, hc_alarm_pkg::OFS_STATUS, 0); chk(q & 32'h3ff, 32'h100);
    ev_req <= 1'b1;
    repeat (3) @(posedge hclk);
    ev_req <= 1'b0;
    repeat (3) @(posedge hclk); chk({31'h0, a1}, 32'h0);
    $display("test latching done");
    bus(1, hc_alarm_pkg::OFS_CTRL, 32'h2);
    bus(1, hc_alarm_pkg::OFS_BAND, 32'h00646464);
    bus(1, hc_alarm_pkg::OFS_SETPT, 32'd500);
    bus(1, hc_alarm_pkg::OFS_PV1, 32'd500);
    repeat (4) @(posedge hclk); chk({12'h0, pd, sd}, 32'h0);
    bus(1, hc_alarm_pkg::OFS_BAND, 32'h00679c64);
    repeat (4) @(posedge hclk); chk(32'(pd != 0 && sd != 0), 32'h1);
    bus(1, hc_alarm_pkg::OFS_CTRL, 32'h1);
    bus(1, hc_alarm_pkg::OFS_PV1, 32'd600);
    repeat (4) @(posedge hclk); chk(32'(pd != 0), 32'h1);
    $display("test heat cool done");
    bus(1, hc_alarm_pkg::OFS_CTRL, 32'h0);
    bus(1, hc_alarm_pkg::OFS_DWELL, 32'd40);
    bus(1, hc_alarm_pkg::OFS_ALM2, 32'h3a);
    bus(1, hc_alarm_pkg::OFS_SETPT, 32'd100);
    bus(1, hc_alarm_pkg::OFS_PV1, 32'd200);
    repeat (100) @(posedge hclk); chk({31'h0, a2}, 32'h0);
    repeat (200) @(posedge hclk); chk({31'h0, a2}, 32'h1);
    $display("test dwell done");
    finish_test;
  end
endmodule // testbench
